// ==== rtl/jisp_pkg.sv ====
// package for the boundary-scan and in-system programming port.
// assumes the test clock is the link clock and mclk is the device core clock.
package jisp_pkg;
  localparam int IR_W    = 10;
  localparam int DR_W    = 32;
  localparam int VER_W   = 4;
  localparam int PART_W  = 16;
  localparam int MAKER_W = 11;
  localparam int BSR_MIN = 96;

  // instruction codes
  localparam logic [IR_W-1:0] INS_SAMPLE  = 10'h005;
  localparam logic [IR_W-1:0] INS_EXTEST  = 10'h000;
  localparam logic [IR_W-1:0] INS_IDENT   = 10'h059;
  localparam logic [IR_W-1:0] INS_USERSIG = 10'h079;
  localparam logic [IR_W-1:0] INS_PROGEN  = 10'h2cc;
  localparam logic [IR_W-1:0] INS_PROGWR  = 10'h2f4;
  localparam logic [IR_W-1:0] INS_PROGDIS = 10'h201;
  localparam logic [IR_W-1:0] INS_BYPASS  = 10'h3ff;
  // captured into the instruction register, two low bits fixed 01
  localparam logic [IR_W-1:0] IR_CAPTURE  = 10'h001;
  localparam logic            ID_LSB      = 1'b1;

  // programming write word: bit 31 completion flag, low bits signature
  localparam int PW_DONE_BIT = 31;

  typedef enum logic [3:0] {
    TRESET, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jisp_tap_e;
endpackage

// ==== rtl/jisp_port.sv ====
// test access port with programming control and user pin gating.
// assumes tck is the programmer's clock and may stop between scans; mclk
// runs free and owns the pin gating. pin inputs arrive from the board.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - the device offers a four-signal test access port and programming is done through it.
// - the instruction register is exactly ten bits long.
// - the user signature is 32 bits and reads out as one 32-bit shift.
// - the boundary-scan chain length is a parameter of 96, 192, 288, 480 or 624 cells.
// - the identification word is version, part number, maker field and a fixed one bit.
// - a completion flag written last keeps all user pins undriven until it is set.
// - during programming all user pins float with a weak pull-up.
// - an output buffer drives only while its enable control is high.
// - pin feedback and macrocell feedback are separate paths.
// - programming follows the in-system configuration standard for shared chains.
// - the identification word has its msb on the left and the fixed one as lsb.
module jisp_port #(
  parameter int              BSR_LEN   = 96,
  parameter int              PIN_N     = BSR_LEN / 3,
  parameter logic [3:0]      VERSION   = 4'h1,      // arbitrary
  parameter logic [15:0]     PART_NUM  = 16'h1234,  // arbitrary
  parameter logic [10:0]     MAKER_ID  = 11'h055    // arbitrary
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             clkEn,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  output logic                  tdo,
  output logic                  tdoEn,
  input  wire logic [PIN_N-1:0] userOut,
  input  wire logic [PIN_N-1:0] userOe,
  input  wire logic [PIN_N-1:0] pinIn,
  output logic      [PIN_N-1:0] pinOut,
  output logic      [PIN_N-1:0] pinOe,
  output logic      [PIN_N-1:0] pinPullUp,
  output logic      [PIN_N-1:0] pinFeedback,
  output logic                  programComplete
);
  localparam logic [jisp_pkg::DR_W-1:0] IDENT_WORD =
    {VERSION, PART_NUM, MAKER_ID, jisp_pkg::ID_LSB};

  jisp_pkg::jisp_tap_e              tapState;
  logic [jisp_pkg::IR_W-1:0]        irShift_q;
  logic [jisp_pkg::IR_W-1:0]        irActive_q;
  logic [jisp_pkg::DR_W-1:0]        drShift_q;
  logic [BSR_LEN-1:0]               bsrShift_q;
  logic [BSR_LEN-1:0]               bsrUpd_q;
  logic                             bypass_q;
  logic [jisp_pkg::DR_W-1:0]        userSig_q;
  logic                             doneFlag_q;
  logic                             progMode_q;
  logic                             tdo_q;
  logic                             tdoEn_q;
  logic [PIN_N-1:0]                 pinInMeta_q;
  logic [PIN_N-1:0]                 pinInSync_q;
  logic [1:0]                       progSync_q;
  logic [1:0]                       doneSync_q;
  logic [1:0]                       extSync_q;
  logic [PIN_N-1:0]                 pinOut_q;
  logic [PIN_N-1:0]                 pinOe_q;
  logic [PIN_N-1:0]                 pinPull_q;
  logic [PIN_N-1:0]                 pinFb_q;
  logic                             complete_q;
  logic                             bsrTgl_q;
  logic [2:0]                       tglSync_q;
  logic [2*PIN_N-1:0]               bsrHold_q;

  function automatic logic isDataReg(input logic [jisp_pkg::IR_W-1:0] ins,
                                     input logic [jisp_pkg::IR_W-1:0] code);
    isDataReg = (ins == code);
  endfunction

  initial begin
    if (!(BSR_LEN == jisp_pkg::BSR_MIN || BSR_LEN == 192 || BSR_LEN == 288 ||
          BSR_LEN == 480 || BSR_LEN == 624)) begin
      $error("boundary chain length not a supported size");
    end
  end

  jisp_tap_fsm u_tap (
    .tck       (tck),
    .trstLow_b (rst_b),
    .tms       (tms),
    .state     (tapState)
  );

  // instruction register: capture, shift, update
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      irShift_q  <= jisp_pkg::IR_CAPTURE;
      irActive_q <= jisp_pkg::INS_IDENT;
    end else begin
      case (tapState)
        jisp_pkg::TRESET: irActive_q <= jisp_pkg::INS_IDENT;
        jisp_pkg::CAP_IR: irShift_q  <= jisp_pkg::IR_CAPTURE;
        jisp_pkg::SH_IR:  irShift_q  <= {tdi, irShift_q[jisp_pkg::IR_W-1:1]};
        jisp_pkg::UPD_IR: irActive_q <= irShift_q;
        default: ;
      endcase
    end
  end

  // 32-bit data register shared by identification, signature and program write
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      drShift_q <= '0;
    end else if (tapState == jisp_pkg::CAP_DR) begin
      if (isDataReg(irActive_q, jisp_pkg::INS_IDENT)) begin
        drShift_q <= IDENT_WORD;
      end else if (isDataReg(irActive_q, jisp_pkg::INS_USERSIG)) begin
        drShift_q <= userSig_q;
      end else begin
        drShift_q <= '0;
      end
    end else if (tapState == jisp_pkg::SH_DR) begin
      drShift_q <= {tdi, drShift_q[jisp_pkg::DR_W-1:1]};
    end
  end

  // boundary chain; pins captured from the synchronised inputs
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      bsrShift_q <= '0;
      bsrUpd_q   <= '0;
      bypass_q   <= 1'b0;
      bsrTgl_q   <= 1'b0;
    end else begin
      if (tapState == jisp_pkg::CAP_DR) begin
        bsrShift_q <= {{(BSR_LEN - PIN_N){1'b0}}, pinInSync_q};
        bypass_q   <= 1'b0;
      end else if (tapState == jisp_pkg::SH_DR) begin
        bsrShift_q <= {tdi, bsrShift_q[BSR_LEN-1:1]};
        bypass_q   <= tdi;
      end else if (tapState == jisp_pkg::UPD_DR &&
                   isDataReg(irActive_q, jisp_pkg::INS_EXTEST)) begin
        bsrUpd_q <= bsrShift_q;
        bsrTgl_q <= ~bsrTgl_q;
      end
    end
  end

  // programming session; the completion flag only comes from the final write
  // with its flag bit set, so an interrupted pass leaves pins quiet
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      progMode_q <= 1'b0;
      doneFlag_q <= 1'b0;
      userSig_q  <= '0;
    end else if (tapState == jisp_pkg::UPD_IR) begin
      if (isDataReg(irShift_q, jisp_pkg::INS_PROGEN)) begin
        progMode_q <= 1'b1;
        doneFlag_q <= 1'b0;
      end else if (isDataReg(irShift_q, jisp_pkg::INS_PROGDIS)) begin
        progMode_q <= 1'b0;
      end
    end else if (tapState == jisp_pkg::UPD_DR && progMode_q &&
                 isDataReg(irActive_q, jisp_pkg::INS_PROGWR)) begin
      userSig_q  <= drShift_q;
      doneFlag_q <= drShift_q[jisp_pkg::PW_DONE_BIT];
    end
  end

  // tdo changes on the falling edge, as the port expects
  always_ff @(negedge tck or negedge rst_b) begin
    if (!rst_b) begin
      tdo_q   <= 1'b0;
      tdoEn_q <= 1'b0;
    end else begin
      tdoEn_q <= (tapState == jisp_pkg::SH_DR) || (tapState == jisp_pkg::SH_IR);
      if (tapState == jisp_pkg::SH_IR) begin
        tdo_q <= irShift_q[0];
      end else if (isDataReg(irActive_q, jisp_pkg::INS_IDENT) ||
                   isDataReg(irActive_q, jisp_pkg::INS_USERSIG) ||
                   isDataReg(irActive_q, jisp_pkg::INS_PROGWR)) begin
        tdo_q <= drShift_q[0];
      end else if (isDataReg(irActive_q, jisp_pkg::INS_EXTEST) ||
                   isDataReg(irActive_q, jisp_pkg::INS_SAMPLE)) begin
        tdo_q <= bsrShift_q[0];
      end else begin
        tdo_q <= bypass_q;
      end
    end
  end

  // level crossings into mclk: two flops each, first flop read only by second
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinInMeta_q <= '0;
      pinInSync_q <= '0;
    end else if (clkEn) begin
      pinInMeta_q <= pinIn;
      pinInSync_q <= pinInMeta_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      progSync_q <= '0;
      doneSync_q <= '0;
      extSync_q  <= '0;
    end else if (clkEn) begin
      progSync_q <= {progSync_q[0], progMode_q};
      doneSync_q <= {doneSync_q[0], doneFlag_q};
      extSync_q  <= {extSync_q[0], isDataReg(irActive_q, jisp_pkg::INS_EXTEST)};
    end
  end

  // only the update toggle crosses; the boundary latch then stays still for a
  // whole scan, far longer than the three mclk the copy needs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tglSync_q <= '0;
      bsrHold_q <= '0;
    end else if (clkEn) begin
      tglSync_q <= {tglSync_q[1:0], bsrTgl_q};
      if (tglSync_q[2] != tglSync_q[1]) begin
        bsrHold_q <= bsrUpd_q[2*PIN_N-1:0];
      end
    end
  end

  // pin gating on mclk
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut_q   <= '0;
      pinOe_q    <= '0;
      pinPull_q  <= '0;
      complete_q <= 1'b0;
    end else if (clkEn) begin
      complete_q <= doneSync_q[1];
      if (progSync_q[1]) begin
        pinOe_q   <= '0;
        pinPull_q <= '1;
        pinOut_q  <= '0;
      end else if (!doneSync_q[1]) begin
        pinOe_q   <= '0;
        pinPull_q <= '0;
        pinOut_q  <= '0;
      end else if (extSync_q[1]) begin
        pinOe_q   <= bsrHold_q[2*PIN_N-1:PIN_N];
        pinOut_q  <= bsrHold_q[PIN_N-1:0];
        pinPull_q <= '0;
      end else begin
        pinOe_q   <= userOe;
        pinOut_q  <= userOut & userOe;
        pinPull_q <= '0;
      end
    end
  end

  // pin feedback is its own path, independent of the macrocell output
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinFb_q <= '0;
    end else if (clkEn) begin
      pinFb_q <= pinInSync_q;
    end
  end

  assign tdo             = tdo_q;
  assign tdoEn           = tdoEn_q;
  assign pinOut          = pinOut_q;
  assign pinOe           = pinOe_q;
  assign pinPullUp       = pinPull_q;
  assign pinFeedback     = pinFb_q;
  assign programComplete = complete_q;

  property p_no_drive_until_done;
    @(posedge mclk) disable iff (!rst_b)
      !complete_q |-> (pinOe_q == '0);
  endproperty
  a_no_drive_until_done: assert property (p_no_drive_until_done)
    else $error("pins driven before completion flag");

  property p_prog_pullup;
    @(posedge mclk) disable iff (!rst_b)
      (clkEn && progSync_q[1]) |=> (pinOe_q == '0) && (pinPull_q == '1);
  endproperty
  a_prog_pullup: assert property (p_prog_pullup)
    else $error("pins not floated with pull-up in programming");

  property p_oe_follows;
    @(posedge mclk) disable iff (!rst_b)
      (clkEn && doneSync_q[1] && !progSync_q[1] && !extSync_q[1]) |=>
        (pinOe_q == $past(userOe)) && ((pinOut_q & ~pinOe_q) == '0);
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("output enable not honoured");

  property p_ir_update;
    @(posedge tck) disable iff (!rst_b)
      (tapState == jisp_pkg::UPD_IR) |=> (irActive_q == $past(irShift_q));
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("instruction not latched on update");

  property p_id_capture;
    @(posedge tck) disable iff (!rst_b)
      (tapState == jisp_pkg::CAP_DR && irActive_q == jisp_pkg::INS_IDENT) |=>
        (drShift_q == IDENT_WORD) && (drShift_q[0] == 1'b1);
  endproperty
  a_id_capture: assert property (p_id_capture)
    else $error("identification not captured");

  property p_sig_capture;
    @(posedge tck) disable iff (!rst_b)
      (tapState == jisp_pkg::CAP_DR && irActive_q == jisp_pkg::INS_USERSIG) |=>
        (drShift_q == $past(userSig_q));
  endproperty
  a_sig_capture: assert property (p_sig_capture)
    else $error("signature not captured");

  property p_dr_shift;
    @(posedge tck) disable iff (!rst_b)
      (tapState == jisp_pkg::SH_DR) |=>
        (drShift_q[jisp_pkg::DR_W-2:0] == $past(drShift_q[jisp_pkg::DR_W-1:1]));
  endproperty
  a_dr_shift: assert property (p_dr_shift)
    else $error("data not shifted lsb first");

  property p_reset_state;
    @(posedge tck) disable iff (!rst_b)
      (tms && tapState == jisp_pkg::SEL_IR) |=> (tapState == jisp_pkg::TRESET);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("controller did not reach reset");

  property p_progen_clears;
    @(posedge tck) disable iff (!rst_b)
      (tapState == jisp_pkg::UPD_IR && irShift_q == jisp_pkg::INS_PROGEN) |=>
        (progMode_q && !doneFlag_q);
  endproperty
  a_progen_clears: assert property (p_progen_clears)
    else $error("programming entry did not clear completion");

  property p_extest_pins;
    @(posedge mclk) disable iff (!rst_b)
      (clkEn && doneSync_q[1] && !progSync_q[1] && extSync_q[1]) |=>
        (pinOe_q == $past(bsrHold_q[2*PIN_N-1:PIN_N])) && (pinPull_q == '0);
  endproperty
  a_extest_pins: assert property (p_extest_pins)
    else $error("boundary update not driven to pins");
endmodule
`default_nettype wire

// ==== rtl/jisp_tap_fsm.sv ====
// sixteen-state test access controller.
// assumes tms is already in the test clock domain.
`timescale 1ns/1ps
`default_nettype none
module jisp_tap_fsm (
  input  wire logic             tck,
  input  wire logic             trstLow_b,
  input  wire logic             tms,
  output jisp_pkg::jisp_tap_e   state
);
  jisp_pkg::jisp_tap_e stateQ;
  jisp_pkg::jisp_tap_e stateD;

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      jisp_pkg::TRESET: stateD = tms ? jisp_pkg::TRESET : jisp_pkg::IDLE;
      jisp_pkg::IDLE:   stateD = tms ? jisp_pkg::SEL_DR : jisp_pkg::IDLE;
      jisp_pkg::SEL_DR: stateD = tms ? jisp_pkg::SEL_IR : jisp_pkg::CAP_DR;
      jisp_pkg::CAP_DR: stateD = tms ? jisp_pkg::EX1_DR : jisp_pkg::SH_DR;
      jisp_pkg::SH_DR:  stateD = tms ? jisp_pkg::EX1_DR : jisp_pkg::SH_DR;
      jisp_pkg::EX1_DR: stateD = tms ? jisp_pkg::UPD_DR : jisp_pkg::PAU_DR;
      jisp_pkg::PAU_DR: stateD = tms ? jisp_pkg::EX2_DR : jisp_pkg::PAU_DR;
      jisp_pkg::EX2_DR: stateD = tms ? jisp_pkg::UPD_DR : jisp_pkg::SH_DR;
      jisp_pkg::UPD_DR: stateD = tms ? jisp_pkg::SEL_DR : jisp_pkg::IDLE;
      jisp_pkg::SEL_IR: stateD = tms ? jisp_pkg::TRESET : jisp_pkg::CAP_IR;
      jisp_pkg::CAP_IR: stateD = tms ? jisp_pkg::EX1_IR : jisp_pkg::SH_IR;
      jisp_pkg::SH_IR:  stateD = tms ? jisp_pkg::EX1_IR : jisp_pkg::SH_IR;
      jisp_pkg::EX1_IR: stateD = tms ? jisp_pkg::UPD_IR : jisp_pkg::PAU_IR;
      jisp_pkg::PAU_IR: stateD = tms ? jisp_pkg::EX2_IR : jisp_pkg::PAU_IR;
      jisp_pkg::EX2_IR: stateD = tms ? jisp_pkg::UPD_IR : jisp_pkg::SH_IR;
      jisp_pkg::UPD_IR: stateD = tms ? jisp_pkg::SEL_DR : jisp_pkg::IDLE;
      default:          stateD = jisp_pkg::TRESET;
    endcase
  end

  always_ff @(posedge tck or negedge trstLow_b) begin
    if (!trstLow_b) begin
      stateQ <= jisp_pkg::TRESET;
    end else begin
      stateQ <= stateD;
    end
  end

  assign state = stateQ;
endmodule
`default_nettype wire

// ==== verification/jisp_port_tb.sv ====
// bench for the test access port: programmer model on tck, pins and board on mclk.
// assumes the default pin count of one third of the scan chain length.
`timescale 1ns/1ps
`default_nettype none
module jisp_port_tb;
  localparam int          BSR   = 96;
  localparam int          PN    = BSR / 3;
  localparam logic [3:0]  VER   = 4'h6;     // arbitrary
  localparam logic [15:0] PART  = 16'h5a3c; // arbitrary
  localparam logic [10:0] MAKER = 11'h2b1;  // arbitrary
  logic          mclk, rst_b, clkEn, tck, tms, tdi, tdo, tdoEn, programComplete;
  wire logic     tdoLine;
  logic [PN-1:0] userOut, userOe, pinOut, pinOe, pinPullUp, pinFeedback, boardVal, boardOe, floatPat;
  wire logic [PN-1:0] pinIn;
  int            numErrors, testsRun, cyc, progActive, flagSet, len;
  logic [31:0]   seed, w, got, expWord;
  logic [9:0]    cap;
  logic [9:0]    unknownCodes [2];
  logic          bypassQ [$];

  // released data-out is pulled high; undriven, unpulled pins wander
  assign tdoLine = tdoEn ? tdo : 1'b1;
  assign pinIn = (pinOe & pinOut) | (~pinOe & boardOe & boardVal) | (~pinOe & ~boardOe & (pinPullUp | floatPat));

  jisp_port #(.BSR_LEN(BSR), .VERSION(VER), .PART_NUM(PART), .MAKER_ID(MAKER)) uut (
    .mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoEn(tdoEn), .userOut(userOut), .userOe(userOe), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPullUp(pinPullUp), .pinFeedback(pinFeedback), .programComplete(programComplete));

  jisp_prog_model prog (.tck(tck), .tms(tms), .tdi(tdi), .tdoLine(tdoLine));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("errors %0d of %0d checks", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // run-away guard, far above the expected length of the run
  always @(posedge mclk) begin
    floatPat <= ~floatPat;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      numErrors++;
      giveVerdict();
    end
  end

  task automatic ir(input logic [9:0] c);
    prog.load_ir(c, cap);
    check(32'(cap), 32'(jisp_pkg::IR_CAPTURE));
    if (c === jisp_pkg::INS_PROGEN) progActive = 1;
    if (c === jisp_pkg::INS_PROGDIS) progActive = 0;
  endtask

  task automatic drive_user();
    @(posedge mclk);
    #1;
    userOut = xorshift();
    userOe = xorshift();
  endtask

  // the gating takes a few mclk after the tck update, so allow eight
  task automatic check_pins();
    logic [PN-1:0] eo;
    repeat (8) @(posedge mclk);
    #1;
    eo = (flagSet != 0 && progActive == 0) ? userOe : '0;
    check(pinOe, eo);
    check(pinOut & eo, userOut & eo);
    check(32'(programComplete), 32'(flagSet));
    if (progActive != 0) check(pinPullUp, '1);
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (4) @(posedge mclk);
    #1 rst_b = 1'b1;
    flagSet = 0;
    progActive = 0;
    prog.tlr();
  endtask

  initial begin
    clkEn = 1'b1;
    rst_b = 1'b0;
    userOut = '0;
    userOe = '0;
    boardVal = '0;
    boardOe = '0;
    floatPat = 32'h5555_5555;
    seed = 32'h0000_97d2;
    numErrors = 0;
    testsRun = 0;
    cyc = 0;
    unknownCodes = '{jisp_pkg::INS_BYPASS, 10'h155};
    do_reset();
    prog.dr32(32'h0000_0000, got);
    check(got, {VER, PART, MAKER, jisp_pkg::ID_LSB});
    ir(jisp_pkg::INS_IDENT);
    prog.dr32(xorshift(), got);
    check(got, {VER, PART, MAKER, 1'b1});
    foreach (unknownCodes[k]) begin
      ir(unknownCodes[k]);
      w = xorshift();
      prog.dr32(w, got);
      // one-bit bypass stage: captured zero first, then each bit one shift late
      bypassQ = {1'b0};
      for (int b = 0; b < 32; b++) begin
        bypassQ.push_back(w[b]);
        expWord[b] = bypassQ.pop_front();
      end
      check(got, expWord);
    end
    drive_user();
    check_pins();
    // pass broken off before the completion flag: pins stay quiet
    ir(jisp_pkg::INS_PROGEN);
    check_pins();
    ir(jisp_pkg::INS_PROGWR);
    prog.dr32(xorshift() & 32'h7fff_ffff, got);
    ir(jisp_pkg::INS_PROGDIS);
    drive_user();
    check_pins();
    // full pass, flag written last
    ir(jisp_pkg::INS_PROGEN);
    ir(jisp_pkg::INS_PROGWR);
    w = xorshift() | 32'h8000_0000;
    prog.dr32(w, got);
    flagSet = 1;
    check_pins();
    @(posedge mclk);
    #1;
    boardOe = '1;
    boardVal = xorshift();
    repeat (6) @(posedge mclk);
    #1 check(pinFeedback, boardVal);
    boardOe = '0;
    ir(jisp_pkg::INS_PROGDIS);
    repeat (3) begin
      drive_user();
      check_pins();
    end
    // clock enable low: pin gating holds its last enables
    got = userOe;
    clkEn = 1'b0;
    drive_user();
    repeat (8) @(posedge mclk);
    #1 check(pinOe, got);
    clkEn = 1'b1;
    check_pins();
    ir(jisp_pkg::INS_USERSIG);
    prog.dr32(xorshift(), got);
    check(got & 32'h7fff_ffff, w & 32'h7fff_ffff);
    // boundary update: one marker lands on the enable cell of pin 3
    ir(jisp_pkg::INS_EXTEST);
    prog.bsr_probe(40, 101, len);
    repeat (8) @(posedge mclk);
    #1 check(pinOe, 32'h0000_0008);
    check(pinOut, '0);
    ir(jisp_pkg::INS_SAMPLE);
    prog.bsr_probe(BSR + 8, 2 * BSR + 24, len);
    check(32'(len), 32'(BSR));
    // controller reset from idle through select-ir brings identification back
    prog.tlr();
    prog.dr32(xorshift(), got);
    check(got, {VER, PART, MAKER, 1'b1});
    // the flag is volatile: a second reset must float the pins again
    @(posedge mclk);
    #1;
    do_reset();
    drive_user();
    check_pins();
    giveVerdict();
  end
endmodule
`default_nettype wire

// ==== verification/jisp_prog_model.sv ====
// programmer model: drives the four-wire test port bit by bit.
// assumes tdoLine is the resolved data-out wire, pulled high when released.
`timescale 1ns/1ps
`default_nettype none
module jisp_prog_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdoLine
);
  // tck rests low between frames, so the port sees no stray edges
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // change just after the falling edge, sample on the rising edge
  task automatic bit1(input logic m, input logic d, output logic o);
    #1;
    tms = m;
    tdi = d;
    #20 tck = 1'b1;
    o = tdoLine;
    #27 tck = 1'b0;
  endtask

  // tms path taken lsb first
  task automatic walk(input logic [7:0] ms, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      bit1(ms[i], 1'b0, o);
    end
  endtask

  task automatic tlr();
    walk(8'h1f, 6);
  endtask

  task automatic load_ir(input logic [9:0] code, output logic [9:0] cap);
    walk(8'h03, 4);
    for (int i = 0; i < 10; i++) begin
      bit1(i == 9, code[i], cap[i]);
    end
    walk(8'h01, 2);
  endtask

  // each scan writes din and reads back dout in the same pass; the bench sequence is fixed
  task automatic dr32(input logic [31:0] din, output logic [31:0] dout);
    walk(8'h01, 3);
    for (int i = 0; i < 32; i++) begin
      bit1(i == 31, din[i], dout[i]);
    end
    walk(8'h01, 2);
  endtask

  // flush with zeros, inject one marker, count shifts until it reappears
  task automatic bsr_probe(input int flush, input int lim, output int len);
    logic o;
    len = -1;
    walk(8'h01, 3);
    for (int i = 0; i < lim; i++) begin
      bit1(i == lim - 1, i == flush, o);
      if (o === 1'b1 && i > flush && len < 0) begin
        len = i - flush;
      end
    end
    walk(8'h01, 2);
  endtask
endmodule
`default_nettype wire
